// File: hdl/dcef_pkg.sv
// Shared constants and types for the DMA channel event flag block
package dcef_pkg;
    localparam int NUM_CH       = 8;
    localparam int FLAGS_PER_CH = 4;
    localparam int DATA_W       = 32;
    localparam int ADDR_W       = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CLEAR  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h08;

    // Field positions inside one channel nibble
    localparam int BIT_ANY   = 0;
    localparam int BIT_DONE  = 1;
    localparam int BIT_HALF  = 2;
    localparam int BIT_FAULT = 3;

    // Reset values
    localparam logic [DATA_W-1:0] RST_STATUS = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_IRQ_EN = 32'h0000_0000;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Per-channel hardware event strobes
    typedef struct packed {
        logic fault;
        logic half;
        logic done;
    } dcef_evt_t;

    // Register file view handed to the flag logic
    typedef struct packed {
        logic              clr_stb;
        logic [DATA_W-1:0] clr_data;
    } dcef_clr_t;
endpackage

// File: hdl/dcef_axil_slave.sv
// AXI4-Lite slave front end: one write and one read at a time
`timescale 1ns/100ps
`default_nettype none
module dcef_axil_slave #(
    parameter int ADDR_W = dcef_pkg::ADDR_W,
    parameter int DATA_W = dcef_pkg::DATA_W
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_awaddr,
    input  wire logic              s_awvalid,
    output logic                   s_awready,
    input  wire logic [DATA_W-1:0] s_wdata,
    input  wire logic [3:0]        s_wstrb,
    input  wire logic              s_wvalid,
    output logic                   s_wready,
    output logic [1:0]             s_bresp,
    output logic                   s_bvalid,
    input  wire logic              s_bready,
    input  wire logic [ADDR_W-1:0] s_araddr,
    input  wire logic              s_arvalid,
    output logic                   s_arready,
    output logic [DATA_W-1:0]      s_rdata,
    output logic [1:0]             s_rresp,
    output logic                   s_rvalid,
    input  wire logic              s_rready,
    output logic                   wr_stb,
    output logic [ADDR_W-1:0]      wr_addr,
    output logic [DATA_W-1:0]      wr_data,
    output logic [3:0]             wr_strb,
    input  wire logic              wr_err,
    output logic [ADDR_W-1:0]      rd_addr,
    input  wire logic [DATA_W-1:0] rd_data,
    input  wire logic              rd_err
);
    logic              aw_held_ff;
    logic              w_held_ff;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [DATA_W-1:0] wdata_ff;
    logic [3:0]        wstrb_ff;
    logic              bvalid_ff;
    logic [1:0]        bresp_ff;
    logic              rvalid_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [1:0]        rresp_ff;

    // Address and data are caught in either order, held until both
    assign s_awready = !aw_held_ff && !bvalid_ff;
    assign s_wready  = !w_held_ff && !bvalid_ff;
    assign wr_stb    = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_addr   = awaddr_ff;
    assign wr_data   = wdata_ff;
    assign wr_strb   = wstrb_ff;
    assign s_bvalid  = bvalid_ff;
    assign s_bresp   = bresp_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            awaddr_ff  <= '0;
            wdata_ff   <= '0;
            wstrb_ff   <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= dcef_pkg::RESP_OKAY;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_held_ff <= 1'b1;
                awaddr_ff  <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_held_ff <= 1'b1;
                wdata_ff  <= s_wdata;
                wstrb_ff  <= s_wstrb;
            end
            if (wr_stb) begin
                aw_held_ff <= 1'b0;
                w_held_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                bresp_ff   <= wr_err ? dcef_pkg::RESP_SLVERR
                                     : dcef_pkg::RESP_OKAY;
            end else if (bvalid_ff && s_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Read: address taken, data returned one edge later
    assign s_arready = !rvalid_ff;
    assign rd_addr   = s_araddr;
    assign s_rvalid  = rvalid_ff;
    assign s_rdata   = rdata_ff;
    assign s_rresp   = rresp_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= '0;
            rresp_ff  <= dcef_pkg::RESP_OKAY;
        end else if (s_arvalid && s_arready) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_data;
            rresp_ff  <= rd_err ? dcef_pkg::RESP_SLVERR
                                : dcef_pkg::RESP_OKAY;
        end else if (rvalid_ff && s_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: hdl/dcef_channel_flags.sv
// Four sticky event flags of one DMA channel
`timescale 1ns/100ps
`default_nettype none
module dcef_channel_flags (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire dcef_pkg::dcef_evt_t  evt,
    input  wire logic                 clr_stb,
    input  wire logic [3:0]           clr_bits,
    output logic [3:0]                flags
);
    logic [3:0] flags_ff;
    logic [3:0] nxt_flags;
    logic [3:0] set_bits;
    logic [3:0] clr_eff;
    logic       clr_all;

    // Channel-wide clear knocks out all four flags
    assign clr_all = clr_stb && clr_bits[dcef_pkg::BIT_ANY];

    // Per-flag clears; writing 0 leaves the flag alone
    assign clr_eff[dcef_pkg::BIT_ANY]   = clr_all;
    assign clr_eff[dcef_pkg::BIT_DONE]  = clr_all ||
        (clr_stb && clr_bits[dcef_pkg::BIT_DONE]);
    assign clr_eff[dcef_pkg::BIT_HALF]  = clr_all ||
        (clr_stb && clr_bits[dcef_pkg::BIT_HALF]);
    assign clr_eff[dcef_pkg::BIT_FAULT] = clr_all ||
        (clr_stb && clr_bits[dcef_pkg::BIT_FAULT]);

    // Hardware sets; the any-event flag follows every event
    assign set_bits[dcef_pkg::BIT_DONE]  = evt.done;
    assign set_bits[dcef_pkg::BIT_HALF]  = evt.half;
    assign set_bits[dcef_pkg::BIT_FAULT] = evt.fault;
    assign set_bits[dcef_pkg::BIT_ANY]   =
        evt.done || evt.half || evt.fault;

    // Set beats clear so an event in the clear cycle is kept
    assign nxt_flags = set_bits | (flags_ff & ~clr_eff);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_ff <= 4'h0;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    assign flags = flags_ff;
endmodule
`default_nettype wire

// File: hdl/dcef_top.sv
// DMA channel event flags: status, clear and interrupt over AXI4-Lite
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Channel done event sets its done flag, held until software clears.
// - Halfway event sets the halfway flag, held until software clears.
// - Fault event sets the fault flag, held until software clears.
// - Any done, halfway or fault event sets the channel any-event flag.
// - Status is read-only; cleared only by writing ones to clear word.
// - Channel clear-all bit clears all four flags; a 0 does nothing.
// - Done, halfway and fault clear bits clear only their own flag.
// - Clear register sits at offset 0x04, write-only, status layout.
// - Channel n: any at 4n, done 4n+1, halfway 4n+2, fault 4n+3.
// - Eight channels, channel 7 in bits 28 to 31.
// - All flags and clear bits reset to zero.
module dcef_top #(
    parameter int NUM_CH = dcef_pkg::NUM_CH
) (
    input  wire logic                            aclk,
    input  wire logic                            aresetn,
    input  wire logic [dcef_pkg::ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic                            s_axi_awvalid,
    output logic                                 s_axi_awready,
    input  wire logic [dcef_pkg::DATA_W-1:0]     s_axi_wdata,
    input  wire logic [3:0]                      s_axi_wstrb,
    input  wire logic                            s_axi_wvalid,
    output logic                                 s_axi_wready,
    output logic [1:0]                           s_axi_bresp,
    output logic                                 s_axi_bvalid,
    input  wire logic                            s_axi_bready,
    input  wire logic [dcef_pkg::ADDR_W-1:0]     s_axi_araddr,
    input  wire logic                            s_axi_arvalid,
    output logic                                 s_axi_arready,
    output logic [dcef_pkg::DATA_W-1:0]          s_axi_rdata,
    output logic [1:0]                           s_axi_rresp,
    output logic                                 s_axi_rvalid,
    input  wire logic                            s_axi_rready,
    input  wire dcef_pkg::dcef_evt_t [NUM_CH-1:0] ch_evt,
    output logic                                 irq
);
    localparam int SW = dcef_pkg::FLAGS_PER_CH * NUM_CH;

    logic                          wr_stb;
    logic [dcef_pkg::ADDR_W-1:0]   wr_addr;
    logic [dcef_pkg::DATA_W-1:0]   wr_data;
    logic [3:0]                    wr_strb;
    logic                          wr_err;
    logic [dcef_pkg::ADDR_W-1:0]   rd_addr;
    logic [dcef_pkg::DATA_W-1:0]   rd_data;
    logic                          rd_err;
    logic [SW-1:0]                 status;
    logic [SW-1:0]                 clr_mask;
    logic [dcef_pkg::DATA_W-1:0]   irq_en_ff;
    logic [dcef_pkg::DATA_W-1:0]   nxt_irq_en;
    logic [dcef_pkg::DATA_W-1:0]   status_word;
    logic [dcef_pkg::DATA_W-1:0]   byte_mask;
    dcef_pkg::dcef_clr_t           clr;
    logic                          hit_wr_clear;
    logic                          hit_wr_en;
    logic                          hit_wr_status;
    logic                          hit_rd_status;
    logic                          hit_rd_clear;
    logic                          hit_rd_en;

    // Bus protocol handling lives in the slave
    dcef_axil_slave #(
        .ADDR_W (dcef_pkg::ADDR_W),
        .DATA_W (dcef_pkg::DATA_W)
    ) u_slave (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .s_awaddr  (s_axi_awaddr),
        .s_awvalid (s_axi_awvalid),
        .s_awready (s_axi_awready),
        .s_wdata   (s_axi_wdata),
        .s_wstrb   (s_axi_wstrb),
        .s_wvalid  (s_axi_wvalid),
        .s_wready  (s_axi_wready),
        .s_bresp   (s_axi_bresp),
        .s_bvalid  (s_axi_bvalid),
        .s_bready  (s_axi_bready),
        .s_araddr  (s_axi_araddr),
        .s_arvalid (s_axi_arvalid),
        .s_arready (s_axi_arready),
        .s_rdata   (s_axi_rdata),
        .s_rresp   (s_axi_rresp),
        .s_rvalid  (s_axi_rvalid),
        .s_rready  (s_axi_rready),
        .wr_stb    (wr_stb),
        .wr_addr   (wr_addr),
        .wr_data   (wr_data),
        .wr_strb   (wr_strb),
        .wr_err    (wr_err),
        .rd_addr   (rd_addr),
        .rd_data   (rd_data),
        .rd_err    (rd_err)
    );

    // Write decode; low address bits ignored, word aligned
    assign hit_wr_clear  = wr_addr[dcef_pkg::ADDR_W-1:2] ==
                           dcef_pkg::OFS_CLEAR[dcef_pkg::ADDR_W-1:2];
    assign hit_wr_en     = wr_addr[dcef_pkg::ADDR_W-1:2] ==
                           dcef_pkg::OFS_IRQ_EN[dcef_pkg::ADDR_W-1:2];
    assign hit_wr_status = wr_addr[dcef_pkg::ADDR_W-1:2] ==
                           dcef_pkg::OFS_STATUS[dcef_pkg::ADDR_W-1:2];
    // Status writes are accepted with OKAY but change nothing
    assign wr_err = !(hit_wr_clear || hit_wr_en || hit_wr_status);

    // Byte lanes expand to a bit mask
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++) begin : g_lane
            assign byte_mask[8*gb +: 8] = {8{wr_strb[gb]}};
        end
    endgenerate

    // Clear word is a pulse; nothing is stored, so it reads back as zero
    assign clr_mask     = wr_data[SW-1:0] & byte_mask[SW-1:0];
    assign clr.clr_stb  = wr_stb && hit_wr_clear;
    assign clr.clr_data = (dcef_pkg::DATA_W)'(clr_mask);

    // One flag group per channel, nibble n at bits 4n..4n+3
    genvar gc;
    generate
        for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
            dcef_channel_flags u_flags (
                .aclk     (aclk),
                .aresetn  (aresetn),
                .evt      (ch_evt[gc]),
                .clr_stb  (clr.clr_stb),
                .clr_bits (clr.clr_data[4*gc +: 4]),
                .flags    (status[4*gc +: 4])
            );
        end
    endgenerate

    // Channel 7 lands in bits 28 to 31 with eight channels
    generate
        if (SW < dcef_pkg::DATA_W) begin : g_pad
            assign status_word = {{(dcef_pkg::DATA_W-SW){1'b0}}, status};
        end else begin : g_full
            assign status_word = status[dcef_pkg::DATA_W-1:0];
        end
    endgenerate

    // Interrupt enable, same layout as status
    assign nxt_irq_en = (wr_stb && hit_wr_en)
                      ? ((irq_en_ff & ~byte_mask) | (wr_data & byte_mask))
                      : irq_en_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_en_ff <= dcef_pkg::RST_IRQ_EN;
        end else begin
            irq_en_ff <= nxt_irq_en;
        end
    end

    // Level interrupt while any enabled flag is pending
    assign irq = |(status_word & irq_en_ff);

    // Read decode; the clear register is write-only and reads zero
    assign hit_rd_status = rd_addr[dcef_pkg::ADDR_W-1:2] ==
                           dcef_pkg::OFS_STATUS[dcef_pkg::ADDR_W-1:2];
    assign hit_rd_clear  = rd_addr[dcef_pkg::ADDR_W-1:2] ==
                           dcef_pkg::OFS_CLEAR[dcef_pkg::ADDR_W-1:2];
    assign hit_rd_en     = rd_addr[dcef_pkg::ADDR_W-1:2] ==
                           dcef_pkg::OFS_IRQ_EN[dcef_pkg::ADDR_W-1:2];
    assign rd_err  = !(hit_rd_status || hit_rd_clear || hit_rd_en);
    assign rd_data = hit_rd_status ? status_word :
                     hit_rd_en     ? irq_en_ff   :
                     dcef_pkg::RST_STATUS;
endmodule
`default_nettype wire

// File: verification/dcef_top_asserts.sv
// Port-level checker for the DMA channel event flag block
`timescale 1ns/100ps
`default_nettype none
module dcef_top_asserts #(
    parameter int NUM_CH = dcef_pkg::NUM_CH
) (
    input wire logic                             aclk,
    input wire logic                             aresetn,
    input wire logic                             s_axi_awvalid,
    input wire logic                             s_axi_awready,
    input wire logic                             s_axi_wvalid,
    input wire logic                             s_axi_wready,
    input wire logic [1:0]                       s_axi_bresp,
    input wire logic                             s_axi_bvalid,
    input wire logic                             s_axi_bready,
    input wire logic                             s_axi_arvalid,
    input wire logic                             s_axi_arready,
    input wire logic [31:0]                      s_axi_rdata,
    input wire logic [1:0]                       s_axi_rresp,
    input wire logic                             s_axi_rvalid,
    input wire logic                             s_axi_rready,
    input wire dcef_pkg::dcef_evt_t [NUM_CH-1:0] ch_evt,
    input wire logic                             irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Request steps of the register bus
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    // Write answered two edges after both taken, read one; both stand
    a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read data late");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    a_slverr_zero: assert property (s_axi_rvalid &&
        s_axi_rresp == dcef_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read with nonzero data");
    a_reset_clean: assert property ($rose(aresetn)
        |-> !s_axi_rvalid && !s_axi_bvalid && !irq) else $error("reset dirty");
    // Interrupt only moves on an event or an applied register write
    a_irq_rise_cause: assert property ($rose(irq) && $past(aresetn)
        |-> $past(|ch_evt) || $rose(s_axi_bvalid)) else $error("irq rose");
    a_irq_fall_cause: assert property ($fell(irq) && $past(aresetn)
        |-> $rose(s_axi_bvalid)) else $error("irq fell without write");
endmodule
bind dcef_top dcef_top_asserts #(.NUM_CH(NUM_CH)) u_dcef_top_asserts (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .ch_evt(ch_evt), .irq(irq));
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the DMA channel event flag block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam logic [1:0] OK  = dcef_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = dcef_pkg::RESP_SLVERR;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, irq, hold_rdy;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, m_stat, m_en, seed;
    logic [1:0]  bresp, rresp;
    dcef_pkg::dcef_evt_t [dcef_pkg::NUM_CH-1:0] ch_evt;
    int          bad_count, samples_checked;

    // Byte strobes tied: every write is a whole word
    dcef_top u_dcef_top (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ch_evt(ch_evt), .irq(irq));

    // 40 MHz clock
    initial aclk = 1'b0;
    always #12.5 aclk = ~aclk;

    // Expected flags from one cycle of event strobes
    function automatic logic [31:0] evt_map(input logic [23:0] e);
        logic [31:0] s;
        s = 32'h0;
        for (int n = 0; n < 8; n++) begin
            s[4*n+1 +: 3] = e[3*n +: 3];
            s[4*n] = |e[3*n +: 3];
        end
        return s;
    endfunction
    // Clear-all bit widens to the whole channel nibble
    function automatic logic [31:0] clr_map(input logic [31:0] c);
        logic [31:0] m;
        m = c;
        for (int n = 0; n < 8; n++) if (c[4*n]) m[4*n +: 4] = 4'hF;
        return m;
    endfunction
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    task automatic check(input logic [31:0] got, exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Irq is combinational, so look a little after the edge
    task automatic check_irq();
        @(posedge aclk);
        #1;
        check({31'h0, irq}, {31'h0, |(m_stat & m_en)}, "irq");
    endtask
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= !hold_rdy;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        // A late ready leaves the response standing for one more edge
        if (!bready) begin
            bready <= 1'b1;
            @(posedge aclk);
        end
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, er}, "bresp");
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= !hold_rdy;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        // Data must stand until the late ready edge
        if (!rready) begin
            rready <= 1'b1;
            @(posedge aclk);
        end
        rready <= 1'b0;
        check(rdata, exp, "rdata");
        check({30'h0, rresp}, {30'h0, er}, "rresp");
    endtask
    // One cycle of event strobes
    task automatic pulse(input logic [23:0] e);
        @(posedge aclk);
        ch_evt <= e;
        @(posedge aclk);
        ch_evt <= '0;
        m_stat = m_stat | evt_map(e);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Whole run is under two thousand cycles; far beyond that is a hang
    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        tally_and_finish();
    end

    // Main sequence: directed corners, then random traffic
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, hold_rdy} = 7'h0;
        {awaddr, araddr, wdata} = 48'h0;
        ch_evt = '0;
        m_stat = 32'h0;
        m_en = 32'h0;
        seed = 32'hBCC2;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(dcef_pkg::OFS_STATUS, 32'h0, OK);
        rd_chk(dcef_pkg::OFS_IRQ_EN, 32'h0, OK);
        rd_chk(dcef_pkg::OFS_CLEAR, 32'h0, OK);
        rd_chk(8'h0C, 32'h0, ERR);
        check_irq();
        wr(dcef_pkg::OFS_IRQ_EN, 32'hFFFF_FFFF, OK);
        m_en = 32'hFFFF_FFFF;
        for (int n = 0; n < 8; n++) begin
            for (int k = 0; k < 3; k++) begin
                pulse(24'h1 << (3*n+k));
                check_irq();
                rd_chk(dcef_pkg::OFS_STATUS, m_stat, OK);
                wr(dcef_pkg::OFS_CLEAR, 32'h2 << (4*n+k), OK);
                m_stat = m_stat & ~(32'h2 << (4*n+k));
                rd_chk(dcef_pkg::OFS_STATUS, m_stat, OK);
            end
            pulse(24'h7 << (3*n));
            wr(dcef_pkg::OFS_CLEAR, 32'h0, OK);
            wr(dcef_pkg::OFS_STATUS, 32'h0, OK);
            rd_chk(dcef_pkg::OFS_STATUS, m_stat, OK);
            wr(dcef_pkg::OFS_CLEAR, 32'h1 << (4*n), OK);
            m_stat = 32'h0;
            rd_chk(dcef_pkg::OFS_STATUS, 32'h0, OK);
            check_irq();
        end
        // Event only on the edge that applies the clear: the set must win
        fork
            wr(dcef_pkg::OFS_CLEAR, 32'h0000_000F, OK);
            begin
                @(posedge aclk iff (awvalid && awready));
                ch_evt <= 24'h1;
                @(posedge aclk);
                ch_evt <= '0;
            end
        join
        m_stat = 32'h3;
        rd_chk(dcef_pkg::OFS_STATUS, m_stat, OK);
        repeat (40) begin
            seed = xs(seed);
            hold_rdy = seed[31];
            pulse(seed[23:0]);
            check_irq();
            seed = xs(seed);
            wr(dcef_pkg::OFS_CLEAR, seed, OK);
            m_stat = m_stat & ~clr_map(seed);
            seed = xs(seed);
            wr(dcef_pkg::OFS_IRQ_EN, seed, OK);
            m_en = seed;
            check_irq();
            rd_chk(dcef_pkg::OFS_IRQ_EN, m_en, OK);
            rd_chk(dcef_pkg::OFS_STATUS, m_stat, OK);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
